// [core/wot_pkg.sv]
// Purpose: Constants and types for the wait one-shot pulse timer.
// Assumes: 125 MHz clk_i, Avalon-MM slave with byte addresses.
// Notes: Every register is one 32-bit word; data sits in bits 7:0.
//
// Overview of operation
// - Each accepted trigger gives a wait, then exactly one pulse.
// - Count source is clock divided by 1, 2, 8, or companion underflow.
// - Wait decrements primary count; on underflow the secondary value loads.
// - Secondary underflow reloads primary, ends count, clears one-shot active flag.
// - Wait lasts (prescaler+1)*(primary+1) count-source periods.
// - Pulse lasts (prescaler+1)*(secondary+1) count-source periods.
// - Counting needs run bit set and then a software or pin trigger.
// - Count stops on completion, one-shot stop, run cleared, or forced stop.
// - Interrupt request is raised as the output pulse ends.
// - Pin trigger enable off leaves the pin unused; on makes it a trigger.
// - Prescaler and primary reads return live counter contents.
// - Writes when stopped load reload and counter; while counting reload only.
// - Polarity bit selects the active level of the pulse.
// - Route bit sends the pulse to one of two pins.
// - Timer is stopped after reset; software loads values before starting.
// - Prescaler and counter are separate byte reads and may change between.
// - Run clear or one-shot stop reloads the counter, then stops.
// - Status flag rises one to two source cycles after run is set.
// - Status flag falls one to two source cycles after run is cleared.
// - Forced stop halts the timer at once.
// - Active flag follows start or stop writes after one or two source cycles.
// - Triggers while one-shot is active are ignored.
// - In single-edge mode an edge bit picks rising or falling pin edge.
package wot_pkg;

   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W = 8;

   localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_ONE_SHOT_CTRL = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_TIMER_IO_CTRL = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_TIMER_MODE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRESCALER = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_SECONDARY = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_PRIMARY = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_PIN_ROUTE = 5'h1C;

   // timer_control_reg
   localparam int unsigned BIT_RUN = 0;
   localparam int unsigned BIT_COUNT_STATUS = 1;
   localparam int unsigned BIT_FORCED_STOP = 2;
   // one_shot_control_reg
   localparam int unsigned BIT_OS_START = 0;
   localparam int unsigned BIT_OS_STOP = 1;
   localparam int unsigned BIT_OS_ACTIVE = 2;
   // timer_io_control_reg
   localparam int unsigned BIT_OUT_POLARITY = 0;
   localparam int unsigned BIT_EDGE_SELECT = 2;
   localparam int unsigned BIT_PIN_TRIG_EN = 3;
   localparam int unsigned BIT_BOTH_EDGES = 4;
   // timer_mode_reg, count source select field
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned SRC_MSB = 1;
   // pin_route_reg
   localparam int unsigned BIT_ROUTE = 0;

   localparam logic [1:0] SRC_DIV1 = 2'h0;
   localparam logic [1:0] SRC_DIV2 = 2'h1;
   localparam logic [1:0] SRC_DIV8 = 2'h2;
   localparam logic [1:0] SRC_COMPANION = 2'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   localparam logic [CNT_W-1:0] RST_PRESCALER = 8'hFF;
   localparam logic [CNT_W-1:0] RST_SECONDARY = 8'hFF;
   localparam logic [CNT_W-1:0] RST_PRIMARY = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      WOT_PH_IDLE = 2'b00,
      WOT_PH_WAIT = 2'b01,
      WOT_PH_PULSE = 2'b10
   } wot_phase_t;

endpackage

// [core/wot_timer.sv]
// Purpose: Wait one-shot pulse timer with 8-bit prescaler and Avalon-MM registers.
// Assumes: All inputs synchronous to clk_i; companion underflow is a one-cycle pulse.
// Notes: Count-source edges are enable pulses; no second clock domain.
`timescale 1ns/1ns
module wot_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [wot_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [wot_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [wot_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic companion_underflow_i,
   input wire logic external_trigger_pin_i,
   output logic pulse_output_pin_a_o,
   output logic pulse_output_pin_a_oe_o,
   output logic pulse_output_pin_b_o,
   output logic pulse_output_pin_b_oe_o,
   output logic timer_irq_o
);
   import wot_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   logic wait_r;
   logic req;
   logic acc;
   logic wr_en;
   logic [CNT_W-1:0] wd;

   logic run_r;
   logic status_r;
   wot_phase_t phase_r;
   logic trig_pend_r;
   logic stop_pend_r;
   logic [CNT_W-1:0] pre_rld_r;
   logic [CNT_W-1:0] sec_rld_r;
   logic [CNT_W-1:0] pri_rld_r;
   logic [CNT_W-1:0] pre_cnt_r;
   logic [CNT_W-1:0] cnt_r;
   logic sec_done_r;

   logic pol_r;
   logic edge_r;
   logic both_r;
   logic pin_en_r;
   logic route_r;
   logic [1:0] src_r;
   logic [2:0] div_r;
   logic trig_prev_r;

   logic tick;
   logic pin_edge;
   logic trigger;
   logic wr_ctrl;
   logic wr_os;
   logic forced;
   logic in_pulse;
   logic [CNT_W-1:0] rd_mux;

   // Bus handshake: request is taken at the edge after it appears
   assign req = avs_read_i | avs_write_i;
   assign acc = req & ~wait_r;
   assign wr_en = avs_write_i & acc & avs_byteenable_i[0];
   assign wd = avs_writedata_i[CNT_W-1:0];
   assign wr_ctrl = wr_en & hit(avs_address_i, OFS_TIMER_CTRL);
   assign wr_os = wr_en & hit(avs_address_i, OFS_ONE_SHOT_CTRL);
   assign forced = wr_ctrl & wd[BIT_FORCED_STOP];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~(req & wait_r);
      end
   end

   assign avs_waitrequest_o = wait_r;

   always_comb begin
      rd_mux = CNT_ZERO;
      case (avs_address_i)
         OFS_TIMER_CTRL: begin
            rd_mux[BIT_RUN] = run_r;
            rd_mux[BIT_COUNT_STATUS] = status_r;
         end
         OFS_ONE_SHOT_CTRL: rd_mux[BIT_OS_ACTIVE] = (phase_r != WOT_PH_IDLE);
         OFS_TIMER_IO_CTRL: begin
            rd_mux[BIT_OUT_POLARITY] = pol_r;
            rd_mux[BIT_EDGE_SELECT] = edge_r;
            rd_mux[BIT_PIN_TRIG_EN] = pin_en_r;
            rd_mux[BIT_BOTH_EDGES] = both_r;
         end
         OFS_TIMER_MODE: rd_mux[SRC_MSB:SRC_LSB] = src_r;
         OFS_PRESCALER: rd_mux = pre_cnt_r;
         OFS_SECONDARY: rd_mux = sec_rld_r;
         OFS_PRIMARY: rd_mux = cnt_r;
         OFS_PIN_ROUTE: rd_mux[BIT_ROUTE] = route_r;
         default: rd_mux = CNT_ZERO;
      endcase
   end

   // Read data is latched at the edge that drops waitrequest and holds until the next read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= RD_ZERO;
      end else if (avs_read_i & wait_r) begin
         avs_readdata_o <= {{(DATA_W-CNT_W){1'b0}}, rd_mux};
      end
   end

   // Configuration bits, one register each
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pol_r <= 1'b0;
         edge_r <= 1'b0;
         both_r <= 1'b0;
         pin_en_r <= 1'b0;
      end else if (wr_en & hit(avs_address_i, OFS_TIMER_IO_CTRL)) begin
         pol_r <= wd[BIT_OUT_POLARITY];
         edge_r <= wd[BIT_EDGE_SELECT];
         pin_en_r <= wd[BIT_PIN_TRIG_EN];
         both_r <= wd[BIT_BOTH_EDGES];
      end
   end

   // Source may change mid-count; the next tick simply follows the new rate
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_r <= SRC_DIV1;
      end else if (wr_en & hit(avs_address_i, OFS_TIMER_MODE)) begin
         src_r <= wd[SRC_MSB:SRC_LSB];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         route_r <= 1'b0;
      end else if (wr_en & hit(avs_address_i, OFS_PIN_ROUTE)) begin
         route_r <= wd[BIT_ROUTE];
      end
   end

   // Reload registers always take writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_rld_r <= RST_PRESCALER;
         sec_rld_r <= RST_SECONDARY;
         pri_rld_r <= RST_PRIMARY;
      end else begin
         if (wr_en & hit(avs_address_i, OFS_PRESCALER)) begin
            pre_rld_r <= wd;
         end
         if (wr_en & hit(avs_address_i, OFS_SECONDARY)) begin
            sec_rld_r <= wd;
         end
         if (wr_en & hit(avs_address_i, OFS_PRIMARY)) begin
            pri_rld_r <= wd;
         end
      end
   end

   // Count source enable; the divider runs free so a source switch needs no restart
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_r + 3'h1;
      end
   end

   always_comb begin
      case (src_r)
         SRC_DIV1: tick = 1'b1;
         SRC_DIV2: tick = div_r[0];
         SRC_DIV8: tick = (div_r == DIV8_LAST);
         SRC_COMPANION: tick = companion_underflow_i;
         default: tick = 1'b0;
      endcase
   end

   // Trigger pin edge detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= external_trigger_pin_i;
      end
   end

   always_comb begin
      if (both_r) begin
         pin_edge = external_trigger_pin_i ^ trig_prev_r;
      end else if (edge_r) begin
         pin_edge = external_trigger_pin_i & ~trig_prev_r;
      end else begin
         pin_edge = ~external_trigger_pin_i & trig_prev_r;
      end
   end

   assign trigger = (wr_os & wd[BIT_OS_START]) | (pin_en_r & pin_edge);

   // Timer core, one process per concern; forced stop outranks every tick event
   logic live;
   logic go_up;
   logic go_down;
   logic take_stop;
   logic take_trig;
   logic step;
   logic pre_zero;
   logic cnt_zero;
   logic wrap;
   logic to_pulse;
   logic to_done;
   logic reload_all;
   logic wr_pre;
   logic wr_pri;

   // Stop outranks a pending start at one tick; either outcome is allowed there
   assign go_up = tick & run_r & ~status_r;
   assign go_down = tick & ~run_r & status_r;
   assign live = tick & run_r & status_r;
   assign take_stop = live & stop_pend_r;
   assign take_trig = live & ~stop_pend_r & trig_pend_r;
   assign step = live & ~stop_pend_r & ~trig_pend_r & (phase_r != WOT_PH_IDLE);
   assign pre_zero = (pre_cnt_r == CNT_ZERO);
   assign cnt_zero = (cnt_r == CNT_ZERO);
   assign wrap = step & pre_zero & cnt_zero;
   assign to_pulse = wrap & (phase_r == WOT_PH_WAIT);
   assign to_done = wrap & (phase_r == WOT_PH_PULSE);
   assign reload_all = go_down | take_stop;
   // Counter writes only while stopped; while counting only the reload copies change
   assign wr_pre = wr_en & hit(avs_address_i, OFS_PRESCALER) & ~status_r;
   assign wr_pri = wr_en & hit(avs_address_i, OFS_PRIMARY) & ~status_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
      end else if (forced) begin
         run_r <= 1'b0;
      end else if (wr_ctrl) begin
         run_r <= wd[BIT_RUN];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_r <= 1'b0;
      end else if (forced) begin
         status_r <= 1'b0;
      end else if (go_up) begin
         status_r <= 1'b1;
      end else if (go_down) begin
         status_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_r <= WOT_PH_IDLE;
      end else if (forced | reload_all | to_done) begin
         phase_r <= WOT_PH_IDLE;
      end else if (take_trig) begin
         phase_r <= WOT_PH_WAIT;
      end else if (to_pulse) begin
         phase_r <= WOT_PH_PULSE;
      end
   end

   // A trigger is kept only while armed, idle and not already pending, so a second
   // trigger in the cycle that takes the first cannot restart a running shot
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_pend_r <= 1'b0;
      end else if (forced) begin
         trig_pend_r <= 1'b0;
      end else if (trigger & run_r & status_r & (phase_r == WOT_PH_IDLE) & ~trig_pend_r) begin
         trig_pend_r <= 1'b1;
      end else if (reload_all | take_trig) begin
         trig_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_pend_r <= 1'b0;
      end else if (forced) begin
         stop_pend_r <= 1'b0;
      end else if (wr_os & wd[BIT_OS_STOP]) begin
         stop_pend_r <= 1'b1;
      end else if (reload_all) begin
         stop_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_cnt_r <= RST_PRESCALER;
      end else if (forced) begin
         pre_cnt_r <= pre_rld_r;
      end else if (wr_pre) begin
         pre_cnt_r <= wd;
      end else if (reload_all | (step & pre_zero)) begin
         pre_cnt_r <= pre_rld_r;
      end else if (step) begin
         pre_cnt_r <= pre_cnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= RST_PRIMARY;
      end else if (forced) begin
         cnt_r <= pri_rld_r;
      end else if (wr_pri) begin
         cnt_r <= wd;
      end else if (reload_all | to_done) begin
         cnt_r <= pri_rld_r;
      end else if (to_pulse) begin
         cnt_r <= sec_rld_r;
      end else if (step & pre_zero & ~cnt_zero) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sec_done_r <= 1'b0;
      end else begin
         sec_done_r <= to_done & ~forced;
      end
   end

   // Pins and interrupt: both lag the phase by one clock, so the irq meets the pulse end
   assign in_pulse = (phase_r == WOT_PH_PULSE);

   // The unrouted pin is parked low with its enable off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_output_pin_a_oe_o <= 1'b0;
         pulse_output_pin_b_oe_o <= 1'b0;
      end else begin
         pulse_output_pin_a_oe_o <= ~route_r;
         pulse_output_pin_b_oe_o <= route_r;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_output_pin_a_o <= 1'b0;
         pulse_output_pin_b_o <= 1'b0;
      end else begin
         pulse_output_pin_a_o <= ~route_r & (pol_r ^ in_pulse);
         pulse_output_pin_b_o <= route_r & (pol_r ^ in_pulse);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_irq_o <= 1'b0;
      end else begin
         timer_irq_o <= sec_done_r;
      end
   end

endmodule

// [verification/wot_timer_props.sv]
// Purpose: Port checks for wot_timer.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound to every wot_timer instance.
`timescale 1ns/1ns
module wot_timer_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [wot_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic pulse_output_pin_a_o,
   input wire logic pulse_output_pin_a_oe_o,
   input wire logic pulse_output_pin_b_o,
   input wire logic pulse_output_pin_b_oe_o,
   input wire logic timer_irq_o
);
   import wot_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_bus_ack_once: assert property (s_req |=> s_ack)
      else $error("bus request not answered in one cycle");
   a_ack_has_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
      else $error("bus answer without request");
   a_rdata_holds: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
      else $error("read data changed without a read");
   a_rdata_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_route_exclusive: assert property (!(pulse_output_pin_a_oe_o && pulse_output_pin_b_oe_o))
      else $error("both output pins enabled");
   a_idle_pin_a: assert property (!pulse_output_pin_a_oe_o |-> !pulse_output_pin_a_o)
      else $error("unrouted pin a not low");
   a_idle_pin_b: assert property (!pulse_output_pin_b_oe_o |-> !pulse_output_pin_b_o)
      else $error("unrouted pin b not low");
   a_irq_one_clk: assert property (timer_irq_o |=> !timer_irq_o)
      else $error("interrupt longer than one clock");
   a_irq_pulse_end: assert property (timer_irq_o |-> (pulse_output_pin_a_oe_o ?
      $changed(pulse_output_pin_a_o) : $changed(pulse_output_pin_b_o)))
      else $error("interrupt not at pulse end");
endmodule
bind wot_timer wot_timer_props wot_timer_props_i (.clk_i(clk_i), .rst_i(rst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .pulse_output_pin_a_o(pulse_output_pin_a_o),
   .pulse_output_pin_a_oe_o(pulse_output_pin_a_oe_o), .pulse_output_pin_b_o(pulse_output_pin_b_o),
   .pulse_output_pin_b_oe_o(pulse_output_pin_b_oe_o), .timer_irq_o(timer_irq_o));

// [verification/wot_pulse_load.sv]
// Purpose: Trigger source and pulse load on the timer pins.
// Assumes: Trigger pin is sampled on clk_i.
// Notes: Width and delay in clk_i cycles; delay counts from the last rising trigger.
`timescale 1ns/1ns
module wot_pulse_load (
   input wire logic clk_i,
   input wire logic pol_i,
   input wire logic pin_a_i,
   input wire logic oe_a_i,
   input wire logic pin_b_i,
   input wire logic oe_b_i,
   input wire logic irq_i,
   output logic trig_o,
   output int width_o,
   output int delay_o,
   output int irq_cnt_o
);
   logic act;
   logic act_q = 1'b0;
   logic trig_q = 1'b0;
   int run_w = 0;
   int run_d = 0;
   assign act = (oe_a_i ? pin_a_i : pin_b_i) !== pol_i;
   initial begin
      trig_o = 1'b0;
      irq_cnt_o = 0;
   end
   // Rising edge, then falling edge two clocks later, so either edge mode can start
   task fire;
      @(posedge clk_i);
      trig_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      trig_o <= 1'b0;
   endtask
   always @(posedge clk_i) begin
      act_q <= act;
      trig_q <= trig_o;
      run_d <= (trig_o && !trig_q) ? 1 : run_d + 1;
      run_w <= act ? run_w + 1 : 0;
      if (!act && act_q) width_o <= run_w;
      if (act && !act_q) delay_o <= run_d;
      if (irq_i === 1'b1) irq_cnt_o <= irq_cnt_o + 1;
   end
endmodule

// [verification/test_wot_timer.sv]
// Purpose: Self-checking bench for wot_timer.
// Assumes: Avalon master with one request in flight.
// Notes: Companion underflow pulses every third clock as a steady reference.
`timescale 1ns/1ns
module test_wot_timer;
   import wot_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rd = 1'b0, wr = 1'b0, pol = 1'b0;
   logic wreq, pa, pae, pb, pbe, irq, trig, comp;
   logic [3:0] be = 4'hF;
   logic [1:0] cc = 2'h0;
   logic [ADDR_W-1:0] addr = 5'h00;
   logic [DATA_W-1:0] wdata = 32'h0000_0000, rdata, got;
   int width, delay, irqs, n0, err_count = 0, check_count = 0;
   wot_timer wot_timer_i (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .companion_underflow_i(comp),
      .external_trigger_pin_i(trig), .pulse_output_pin_a_o(pa), .pulse_output_pin_a_oe_o(pae),
      .pulse_output_pin_b_o(pb), .pulse_output_pin_b_oe_o(pbe), .timer_irq_o(irq));
   wot_pulse_load wot_pulse_load_i (.clk_i(clk_i), .pol_i(pol), .pin_a_i(pa), .oe_a_i(pae),
      .pin_b_i(pb), .oe_b_i(pbe), .irq_i(irq), .trig_o(trig), .width_o(width),
      .delay_o(delay), .irq_cnt_o(irqs));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cc <= (cc == 2'h2) ? 2'h0 : cc + 2'h1;
   assign comp = (cc == 2'h2);
   task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task bus(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] dat);
      @(posedge clk_i);
      addr <= a;
      wdata <= {24'h000000, dat};
      wr <= we;
      rd <= !we;
      @(posedge clk_i);
      while (wreq !== 1'b0) @(posedge clk_i);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task poll(input logic v);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_TIMER_CTRL, 8'h00);
         n++;
      end while (got[BIT_COUNT_STATUS] !== v && n < 40);
      chk("count status", v, got[BIT_COUNT_STATUS]);
   endtask
   // Stop first, so that the counts below load the counter as well
   task setup(input logic [1:0] src, input logic [7:0] io, pre, pri, sec);
      bus(1'b1, OFS_TIMER_CTRL, 8'h00);
      poll(1'b0);
      bus(1'b1, OFS_TIMER_MODE, {6'h00, src});
      bus(1'b1, OFS_TIMER_IO_CTRL, io);
      pol <= io[BIT_OUT_POLARITY];
      bus(1'b1, OFS_PRESCALER, pre);
      bus(1'b1, OFS_SECONDARY, sec);
      bus(1'b1, OFS_PRIMARY, pri);
      bus(1'b1, OFS_TIMER_CTRL, 8'h01);
      poll(1'b1);
      n0 = irqs;
   endtask
   task wait_irq;
      for (int n = 0; n < 3000 && irqs == n0; n++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk("irq count", n0 + 1, irqs);
   endtask
   task t_reset;
      bus(1'b0, OFS_TIMER_CTRL, 8'h00);
      chk("ctrl reset", 32'h0, got);
      for (int i = 4; i < 7; i++) begin
         bus(1'b0, 5'(4 * i), 8'h00);
         chk("count reset", 32'hFF, got);
      end
      be <= 4'hE;
      bus(1'b1, OFS_PRESCALER, 8'h12);
      be <= 4'hF;
      bus(1'b1, 5'h02, 8'h5A);
      bus(1'b0, OFS_PRESCALER, 8'h00);
      chk("masked write", 32'hFF, got);
      bus(1'b0, 5'h02, 8'h00);
      chk("unmapped read", 32'h0, got);
   endtask
   task t_shot(input int i);
      int dv;
      dv = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 8 : 3;
      bus(1'b1, OFS_PIN_ROUTE, {7'h00, i[0]});
      setup(2'(i), {7'h00, i[1]}, 8'(i), 8'h02, 8'(i + 1));
      chk("pin b enable", i[0], pbe);
      bus(1'b1, OFS_ONE_SHOT_CTRL, 8'h01);
      wait_irq;
      chk("pulse width", (i + 1) * (i + 2) * dv, width);
      bus(1'b0, OFS_ONE_SHOT_CTRL, 8'h00);
      chk("active cleared", 0, got[BIT_OS_ACTIVE]);
      bus(1'b0, OFS_PRIMARY, 8'h00);
      chk("primary reloaded", 2, got);
   endtask
   task t_pin;
      int d;
      setup(SRC_DIV1, 8'h0C, 8'h01, 8'h01, 8'h00);
      wot_pulse_load_i.fire();
      wait_irq;
      d = delay;
      setup(SRC_DIV1, 8'h0C, 8'h01, 8'h04, 8'h00);
      wot_pulse_load_i.fire();
      wot_pulse_load_i.fire();
      wait_irq;
      chk("retrigger ignored", d + 3, delay);
      setup(SRC_DIV1, 8'h08, 8'h01, 8'h04, 8'h00);
      wot_pulse_load_i.fire();
      wait_irq;
      chk("falling start", d + 8, delay);
      setup(SRC_DIV1, 8'h18, 8'h01, 8'h01, 8'h00);
      wot_pulse_load_i.fire();
      wait_irq;
      chk("both edges", d, delay);
      setup(SRC_DIV1, 8'h04, 8'h01, 8'h01, 8'h00);
      wot_pulse_load_i.fire();
      repeat (30) @(posedge clk_i);
      chk("pin disabled", n0, irqs);
   endtask
   task t_stop;
      logic [7:0] v;
      setup(SRC_DIV8, 8'h00, 8'h00, 8'hC8, 8'h00);
      bus(1'b1, OFS_ONE_SHOT_CTRL, 8'h01);
      repeat (40) @(posedge clk_i);
      bus(1'b0, OFS_PRIMARY, 8'h00);
      v = got[7:0];
      bus(1'b1, OFS_PRIMARY, 8'h33);
      repeat (16) @(posedge clk_i);
      bus(1'b0, OFS_PRIMARY, 8'h00);
      chk("live count", 1, got[7:0] < v && got[7:0] != 8'h33 && v < 8'hC8);
      bus(1'b1, OFS_ONE_SHOT_CTRL, 8'h02);
      repeat (20) @(posedge clk_i);
      bus(1'b0, OFS_ONE_SHOT_CTRL, 8'h00);
      chk("stop bit", 0, got[BIT_OS_ACTIVE]);
      bus(1'b0, OFS_PRIMARY, 8'h00);
      chk("reload on stop", 32'h33, got);
      chk("no pulse", n0, irqs);
      bus(1'b1, OFS_ONE_SHOT_CTRL, 8'h01);
      repeat (20) @(posedge clk_i);
      bus(1'b1, OFS_TIMER_CTRL, 8'h05);
      bus(1'b0, OFS_ONE_SHOT_CTRL, 8'h00);
      chk("forced stop", 0, got[BIT_OS_ACTIVE]);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      for (int i = 0; i < 4; i++) t_shot(i);
      t_pin;
      t_stop;
      wrap_up;
   end
   initial begin
      #200000;
      err_count++;
      wrap_up;
   end
endmodule
